// *** src/ldmc_config_bank.v ***
// Logical device mode configuration registers and the pin logic they steer
//
// Added by the designer: strobed register access.
`default_nettype none
`include "ldmc_map.vh"

// Notes on behaviour
// - Buffer bit clear: second channel data gated by its own buffer enable.
// - Buffer bit set: own enable unused, first channel enable gates data.
// - Disk mode register resets to zero; reserved bits kept zero.
// - Activate register bit 0 controls chip-select and interrupt pins.
// - Inactive without full decode: chip selects and interrupt pin float.
// - Active drives selects; inactive full-decode reads SA13-15; SA12 always.
// - Parallel mode 001 EPP1.9, 101 EPP1.7, 010 ECP.
// - Parallel bits 6:3 hold FIFO threshold, default 0111.
// - Interrupt-type set: pulse request low, then release to float.
// - Interrupt-type clear: request follows nACK level, driven.
// - Interrupt-type ignored in printer and standard modes.
// - Serial bit 0 enables MIDI, cleared at reset.
// - Serial bit 1 enables high speed; reset zero; upper bits zero.
// - Infrared bits 0 and 1 set receive and transmit polarity.
// - Infrared bit 2 selects full or half duplex.
// - Infrared bits 5:3 select standard, IrDA or ASK-IR protocol.
// - Infrared bit 6 routes signals to uart or dedicated pins.
// - Only hard reset restores defaults; soft resets leave registers.
module ldmc_config_bank #(
  parameter PULSE_CYC = `LDMC_PP_PULSE_CYC
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire rstn,
  input wire ce,
  // Register port
  input wire [`LDMC_ADDR_W-1:0] addr,
  input wire [7:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rd_data_ff,
  // Disk channel buffer control
  input wire ch1_data_access,
  input wire ch2_data_access,
  output reg first_channel_buffer_enable_ff,
  output reg second_channel_buffer_enable_ff,
  // Second channel pins
  input wire cs_low_req_n,
  input wire cs_high_req_n,
  input wire drive_chip_select_low_i,
  output reg drive_chip_select_low_o_ff,
  output reg drive_chip_select_low_oe_ff,
  input wire drive_chip_select_high_i,
  output reg drive_chip_select_high_o_ff,
  output reg drive_chip_select_high_oe_ff,
  input wire second_channel_irq_input_i,
  output reg second_channel_irq_input_oe_ff,
  input wire general_select_pin_i,
  output reg ch2_irq_ff,
  output reg [3:0] upper_addr_ff,
  output reg upper_addr_valid_ff,
  // Parallel port
  input wire pp_nack_i,
  input wire pp_irq_event,
  output reg pp_irq_o_ff,
  output reg pp_irq_oe_ff,
  output reg pp_epp19_ff,
  output reg pp_epp17_ff,
  output reg pp_ecp_ff,
  output reg [3:0] pp_fifo_thr_ff,
  // Serial ports
  output reg sp1_midi_ff,
  output reg sp1_high_speed_ff,
  output reg sp2_midi_ff,
  output reg sp2_high_speed_ff,
  // Infrared
  input wire uart2_tx,
  input wire ir_tx_busy,
  output reg uart2_rx_ff,
  input wire second_uart_receive_pin,
  output reg second_uart_transmit_pin_ff,
  input wire infrared_receive_pin,
  output reg infrared_transmit_pin_ff,
  output reg ir_irda_ff,
  output reg ir_ask_ff
);

  localparam PW = 4;
  localparam [PW-1:0] PULSE_LEN = PULSE_CYC[PW-1:0];
  localparam PP_IDLE = 1'b0;
  localparam PP_PULSE = 1'b1;

  reg [7:0] global_ff;
  reg [7:0] activate_ff;
  reg [7:0] ide2_mode_ff;
  reg [7:0] pp_mode_ff;
  reg [7:0] sp1_mode_ff;
  reg [7:0] sp2_mode_ff;
  reg [7:0] ir_opt_ff;
  reg pp_state_ff;
  reg [PW-1:0] pp_cnt_ff;
  reg pp_event_d_ff;

  wire [`LDMC_LDN_W-1:0] ldn = addr[`LDMC_LDN_MSB:`LDMC_LDN_LSB];
  wire [`LDMC_IDX_W-1:0] idx = addr[`LDMC_IDX_MSB:0];
  wire hit_global = (idx == `LDMC_IDX_GLOBAL_OPT);
  wire hit_act = (ldn == `LDMC_LDN_IDE2) && (idx == `LDMC_IDX_ACTIVATE);
  wire hit_ide2 = (ldn == `LDMC_LDN_IDE2) && (idx == `LDMC_IDX_MODE);
  wire hit_pp = (ldn == `LDMC_LDN_PP) && (idx == `LDMC_IDX_MODE);
  wire hit_sp1 = (ldn == `LDMC_LDN_SP1) && (idx == `LDMC_IDX_MODE);
  wire hit_sp2 = (ldn == `LDMC_LDN_SP2) && (idx == `LDMC_IDX_MODE);
  wire hit_ir = (ldn == `LDMC_LDN_SP2) && (idx == `LDMC_IDX_OPTION);

  // Register writes; rstn is the hard reset, nothing else clears these
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      global_ff <= `LDMC_RST_GLOBAL;
      activate_ff <= `LDMC_RST_ACT;
      ide2_mode_ff <= `LDMC_RST_IDE2;
      pp_mode_ff <= `LDMC_RST_PP;
      sp1_mode_ff <= `LDMC_RST_SP;
      sp2_mode_ff <= `LDMC_RST_SP;
      ir_opt_ff <= `LDMC_RST_IR;
    end else if (ce && wr_stb) begin
      // Masks keep reserved positions at zero
      if (hit_global) begin
        global_ff <= wr_data & `LDMC_MASK_GLOBAL;
      end
      if (hit_act) begin
        activate_ff <= wr_data & `LDMC_MASK_ACT;
      end
      if (hit_ide2) begin
        ide2_mode_ff <= wr_data & `LDMC_MASK_IDE2;
      end
      if (hit_pp) begin
        pp_mode_ff <= wr_data & `LDMC_MASK_PP;
      end
      if (hit_sp1) begin
        sp1_mode_ff <= wr_data & `LDMC_MASK_SP;
      end
      if (hit_sp2) begin
        sp2_mode_ff <= wr_data & `LDMC_MASK_SP;
      end
      if (hit_ir) begin
        ir_opt_ff <= wr_data & `LDMC_MASK_IR;
      end
    end
  end

  // Read data one cycle after the strobe, zero elsewhere and when unmapped
  reg [7:0] nxt_rd_data;
  always @* begin
    nxt_rd_data = 8'h00;
    if (rd_stb) begin
      if (hit_global) begin
        nxt_rd_data = global_ff;
      end else if (hit_act) begin
        nxt_rd_data = activate_ff;
      end else if (hit_ide2) begin
        nxt_rd_data = ide2_mode_ff;
      end else if (hit_pp) begin
        nxt_rd_data = pp_mode_ff;
      end else if (hit_sp1) begin
        nxt_rd_data = sp1_mode_ff;
      end else if (hit_sp2) begin
        nxt_rd_data = sp2_mode_ff;
      end else if (hit_ir) begin
        nxt_rd_data = ir_opt_ff;
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= 8'h00;
    end else if (ce) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // Second disk channel
  wire ch2_active = activate_ff[`LDMC_ACTIVE_BIT];
  wire full_dec = global_ff[`LDMC_FULL_DEC_BIT];
  wire share_buf = ide2_mode_ff[`LDMC_IDE2_BUF_BIT];

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      first_channel_buffer_enable_ff <= 1'b0;
      second_channel_buffer_enable_ff <= 1'b0;
      drive_chip_select_low_o_ff <= 1'b1;
      drive_chip_select_low_oe_ff <= 1'b0;
      drive_chip_select_high_o_ff <= 1'b1;
      drive_chip_select_high_oe_ff <= 1'b0;
      second_channel_irq_input_oe_ff <= 1'b0;
      ch2_irq_ff <= 1'b0;
      upper_addr_ff <= 4'h0;
      upper_addr_valid_ff <= 1'b0;
    end else if (ce) begin
      // Shared buffer lets one external transceiver serve both channels
      first_channel_buffer_enable_ff <= ch1_data_access |
        (share_buf & ch2_data_access);
      second_channel_buffer_enable_ff <= ~share_buf &
        ch2_data_access;
      drive_chip_select_low_o_ff <= cs_low_req_n;
      drive_chip_select_high_o_ff <= cs_high_req_n;
      drive_chip_select_low_oe_ff <= ch2_active;
      drive_chip_select_high_oe_ff <= ch2_active;
      second_channel_irq_input_oe_ff <= 1'b0;
      ch2_irq_ff <= ch2_active & second_channel_irq_input_i;
      // SA12 always arrives on the general select pin
      upper_addr_ff[0] <= general_select_pin_i;
      upper_addr_ff[1] <= drive_chip_select_low_i;
      upper_addr_ff[2] <= drive_chip_select_high_i;
      upper_addr_ff[3] <= second_channel_irq_input_i;
      upper_addr_valid_ff <= ~ch2_active & full_dec;
    end
  end

  // Parallel port mode decode
  wire [2:0] pp_mode = pp_mode_ff[`LDMC_PP_MODE_MSB:`LDMC_PP_MODE_LSB];
  wire pp_pulsed = pp_mode_ff[`LDMC_PP_ITYPE_BIT];
  wire pp_plain = (pp_mode == `LDMC_PP_SPP) ||
    (pp_mode == `LDMC_PP_PRINTER);
  wire pp_rise = pp_irq_event & ~pp_event_d_ff;

  // Interrupt pulse machine; plain modes ignore the type bit
  reg nxt_pp_state;
  reg [PW-1:0] nxt_pp_cnt;
  always @* begin
    nxt_pp_state = pp_state_ff;
    nxt_pp_cnt = pp_cnt_ff;
    case (pp_state_ff)
      PP_IDLE: begin
        if (pp_pulsed && !pp_plain && pp_rise) begin
          nxt_pp_state = PP_PULSE;
          nxt_pp_cnt = PULSE_LEN;
        end
      end
      PP_PULSE: begin
        if (pp_cnt_ff <= 4'h1) begin
          nxt_pp_state = PP_IDLE;
          nxt_pp_cnt = 4'h0;
        end else begin
          nxt_pp_cnt = pp_cnt_ff - 4'h1;
        end
      end
      default: begin
        nxt_pp_state = PP_IDLE;
        nxt_pp_cnt = 4'h0;
      end
    endcase
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pp_state_ff <= PP_IDLE;
      pp_cnt_ff <= 4'h0;
      pp_event_d_ff <= 1'b0;
      pp_irq_o_ff <= 1'b1;
      pp_irq_oe_ff <= 1'b0;
      pp_epp19_ff <= 1'b0;
      pp_epp17_ff <= 1'b0;
      pp_ecp_ff <= 1'b0;
      pp_fifo_thr_ff <= 4'h0;
    end else if (ce) begin
      pp_state_ff <= nxt_pp_state;
      pp_cnt_ff <= nxt_pp_cnt;
      pp_event_d_ff <= pp_irq_event;
      if (pp_pulsed && !pp_plain) begin
        // Low only during the pulse, floating otherwise
        pp_irq_o_ff <= 1'b0;
        pp_irq_oe_ff <= (nxt_pp_state == PP_PULSE);
      end else begin
        pp_irq_o_ff <= pp_nack_i;
        pp_irq_oe_ff <= 1'b1;
      end
      pp_epp19_ff <= (pp_mode == `LDMC_PP_EPP19);
      pp_epp17_ff <= (pp_mode == `LDMC_PP_EPP17);
      pp_ecp_ff <= (pp_mode == `LDMC_PP_ECP);
      pp_fifo_thr_ff <= pp_mode_ff[`LDMC_PP_THR_MSB:`LDMC_PP_THR_LSB];
    end
  end

  // Serial port options
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sp1_midi_ff <= 1'b0;
      sp1_high_speed_ff <= 1'b0;
      sp2_midi_ff <= 1'b0;
      sp2_high_speed_ff <= 1'b0;
    end else if (ce) begin
      sp1_midi_ff <= sp1_mode_ff[`LDMC_SP_MIDI_BIT];
      sp1_high_speed_ff <= sp1_mode_ff[`LDMC_SP_HS_BIT];
      sp2_midi_ff <= sp2_mode_ff[`LDMC_SP_MIDI_BIT];
      sp2_high_speed_ff <= sp2_mode_ff[`LDMC_SP_HS_BIT];
    end
  end

  // Infrared routing, polarity and duplex
  wire rx_pol = ir_opt_ff[`LDMC_IR_RXPOL_BIT];
  wire tx_pol = ir_opt_ff[`LDMC_IR_TXPOL_BIT];
  wire half_dup = ir_opt_ff[`LDMC_IR_HALF_BIT];
  wire [2:0] ir_mode = ir_opt_ff[`LDMC_IR_MODE_MSB:`LDMC_IR_MODE_LSB];
  wire alt_pins = ir_opt_ff[`LDMC_IR_MUX_BIT];
  // Reserved protocol codes behave as the standard one
  wire ir_on = (ir_mode == `LDMC_IR_IRDA) ||
    (ir_mode == `LDMC_IR_ASK);
  wire ir_tx = uart2_tx ^ tx_pol;
  wire ir_rx_raw = (alt_pins ? infrared_receive_pin :
    second_uart_receive_pin) ^ rx_pol;
  // Half duplex blanks receive so our own echo is not read back
  wire ir_rx = (half_dup && ir_tx_busy) ? 1'b0 : ir_rx_raw;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      uart2_rx_ff <= 1'b1;
      second_uart_transmit_pin_ff <= 1'b1;
      infrared_transmit_pin_ff <= 1'b0;
      ir_irda_ff <= 1'b0;
      ir_ask_ff <= 1'b0;
    end else if (ce) begin
      ir_irda_ff <= (ir_mode == `LDMC_IR_IRDA);
      ir_ask_ff <= (ir_mode == `LDMC_IR_ASK);
      uart2_rx_ff <= ir_on ? ir_rx : second_uart_receive_pin;
      second_uart_transmit_pin_ff <= (ir_on && !alt_pins) ? ir_tx :
        uart2_tx;
      infrared_transmit_pin_ff <= (ir_on && alt_pins) ? ir_tx :
        tx_pol;
    end
  end

endmodule // ldmc_config_bank
`default_nettype wire

// *** pkg/ldmc_map.vh ***
// Register map, field positions and reset values of the mode config bank
`ifndef LDMC_MAP_VH
`define LDMC_MAP_VH
// Address layout: logical device number above the configuration index
`define LDMC_IDX_W 8
`define LDMC_LDN_W 3
`define LDMC_ADDR_W 11
`define LDMC_LDN_LSB 8
`define LDMC_LDN_MSB 10
`define LDMC_IDX_MSB 7
// Logical device numbers
`define LDMC_LDN_IDE2 3'h2
`define LDMC_LDN_PP 3'h3
`define LDMC_LDN_SP1 3'h4
`define LDMC_LDN_SP2 3'h5
// Configuration indices
`define LDMC_IDX_GLOBAL_OPT 8'h24
`define LDMC_IDX_ACTIVATE 8'h30
`define LDMC_IDX_MODE 8'hF0
`define LDMC_IDX_OPTION 8'hF1
// Writable bit masks, reserved bits stored as zero
`define LDMC_MASK_GLOBAL 8'h40
`define LDMC_MASK_ACT 8'h01
`define LDMC_MASK_IDE2 8'h01
`define LDMC_MASK_PP 8'hFF
`define LDMC_MASK_SP 8'h03
`define LDMC_MASK_IR 8'h7F
// Reset values
`define LDMC_RST_GLOBAL 8'h00
`define LDMC_RST_ACT 8'h00
`define LDMC_RST_IDE2 8'h00
`define LDMC_RST_PP 8'h38
`define LDMC_RST_SP 8'h00
`define LDMC_RST_IR 8'h00
// Field positions
`define LDMC_FULL_DEC_BIT 6
`define LDMC_ACTIVE_BIT 0
`define LDMC_IDE2_BUF_BIT 0
`define LDMC_PP_MODE_MSB 2
`define LDMC_PP_MODE_LSB 0
`define LDMC_PP_THR_MSB 6
`define LDMC_PP_THR_LSB 3
`define LDMC_PP_ITYPE_BIT 7
`define LDMC_SP_MIDI_BIT 0
`define LDMC_SP_HS_BIT 1
`define LDMC_IR_RXPOL_BIT 0
`define LDMC_IR_TXPOL_BIT 1
`define LDMC_IR_HALF_BIT 2
`define LDMC_IR_MODE_MSB 5
`define LDMC_IR_MODE_LSB 3
`define LDMC_IR_MUX_BIT 6
// Parallel port mode codes
`define LDMC_PP_SPP 3'h0
`define LDMC_PP_EPP19 3'h1
`define LDMC_PP_ECP 3'h2
`define LDMC_PP_PRINTER 3'h4
`define LDMC_PP_EPP17 3'h5
// Infrared protocol codes
`define LDMC_IR_STD 3'h0
`define LDMC_IR_IRDA 3'h1
`define LDMC_IR_ASK 3'h2
// Parallel port interrupt pulse width in cycles
`define LDMC_PP_PULSE_CYC 4
`endif

// *** verification/ldmc_monitor.sv ***
// Checker of the mode config bank pin behaviour
`default_nettype none
module ldmc_monitor (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register port
  input wire logic [10:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  // Pins
  input wire logic ch2_data_access,
  input wire logic first_channel_buffer_enable_ff,
  input wire logic second_channel_buffer_enable_ff,
  input wire logic cs_low_req_n,
  input wire logic cs_high_req_n,
  input wire logic drive_chip_select_low_i,
  input wire logic drive_chip_select_low_o_ff,
  input wire logic drive_chip_select_low_oe_ff,
  input wire logic drive_chip_select_high_i,
  input wire logic drive_chip_select_high_o_ff,
  input wire logic drive_chip_select_high_oe_ff,
  input wire logic second_channel_irq_input_i,
  input wire logic second_channel_irq_input_oe_ff,
  input wire logic general_select_pin_i,
  input wire logic ch2_irq_ff,
  input wire logic [3:0] upper_addr_ff,
  input wire logic upper_addr_valid_ff,
  input wire logic pp_nack_i,
  input wire logic pp_irq_o_ff,
  input wire logic pp_irq_oe_ff,
  input wire logic [3:0] pp_fifo_thr_ff,
  // Infrared
  input wire logic uart2_tx,
  input wire logic ir_tx_busy,
  input wire logic second_uart_receive_pin,
  input wire logic infrared_receive_pin,
  input wire logic uart2_rx_ff,
  input wire logic second_uart_transmit_pin_ff,
  input wire logic infrared_transmit_pin_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act_sh, fdec_sh, buf_sh;
  logic [7:0] pp_sh;
  logic [6:0] ir_sh;
  wire pul_sh = pp_sh[7] && pp_sh[1:0] != 2'h0;
  // Only the two listed protocol codes take over the uart pins
  wire iron_sh = ir_sh[5:3] == 3'h1 || ir_sh[5:3] == 3'h2;
  wire infrared_transmit_pin_sh = uart2_tx ^ ir_sh[1];
  wire infrared_receive_pin_sh = (ir_sh[6] ? infrared_receive_pin : second_uart_receive_pin)
    ^ ir_sh[0];
  // Shadow copies so pin checks need no view of the bodies
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {act_sh, fdec_sh, buf_sh} <= 3'h0;
      pp_sh <= 8'h38;
      ir_sh <= 7'h00;
    end else if (wr_stb && ce) begin
      if (addr == 11'h230) act_sh <= wr_data[0];
      if (addr[7:0] == 8'h24) fdec_sh <= wr_data[6];
      if (addr == 11'h2F0) buf_sh <= wr_data[0];
      if (addr == 11'h3F0) pp_sh <= wr_data;
      if (addr == 11'h5F1) ir_sh <= wr_data[6:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  own_buffer_a: assert property ($past(rstn && ce) |->
    second_channel_buffer_enable_ff == $past(!buf_sh && ch2_data_access))
    else $error("second buffer enable wrong");
  shared_buffer_a: assert property (
    $past(rstn && ce && buf_sh && ch2_data_access) |->
    first_channel_buffer_enable_ff)
    else $error("first buffer enable missing");
  select_drive_a: assert property ($past(rstn && ce) |->
    drive_chip_select_low_oe_ff == $past(act_sh) &&
    drive_chip_select_high_oe_ff == $past(act_sh))
    else $error("chip select enable wrong");
  select_value_a: assert property ($past(rstn && ce && act_sh) |->
    drive_chip_select_low_o_ff == $past(cs_low_req_n) &&
    drive_chip_select_high_o_ff == $past(cs_high_req_n))
    else $error("chip select value wrong");
  irq_input_a: assert property (second_channel_irq_input_oe_ff == 1'b0)
    else $error("irq pin driven");
  channel_irq_a: assert property ($past(rstn && ce) |->
    ch2_irq_ff == $past(act_sh && second_channel_irq_input_i))
    else $error("channel irq wrong");
  upper_addr_a: assert property ($past(rstn && ce) |->
    upper_addr_ff == $past({second_channel_irq_input_i,
    drive_chip_select_high_i, drive_chip_select_low_i, general_select_pin_i}))
    else $error("upper address bits wrong");
  decode_valid_a: assert property ($past(rstn && ce) |->
    upper_addr_valid_ff == $past(!act_sh && fdec_sh))
    else $error("upper address valid wrong");
  fifo_thr_a: assert property ($past(rstn && ce) |->
    pp_fifo_thr_ff == $past(pp_sh[6:3]))
    else $error("fifo threshold wrong");
  pp_pulse_a: assert property (
    pul_sh && $past(pul_sh) && $rose(pp_irq_oe_ff) |->
    (pp_irq_oe_ff && !pp_irq_o_ff) [*4] ##1 !pp_irq_oe_ff)
    else $error("irq pulse shape wrong");
  nack_follow_a: assert property ($past(rstn && ce) && !$past(pul_sh) |->
    pp_irq_oe_ff && pp_irq_o_ff == $past(pp_nack_i))
    else $error("irq does not follow nack");
  ir_transmit_a: assert property ($past(rstn && ce) |->
    second_uart_transmit_pin_ff ==
    $past(iron_sh && !ir_sh[6] ? infrared_transmit_pin_sh : uart2_tx) &&
    infrared_transmit_pin_ff ==
    $past(iron_sh && ir_sh[6] ? infrared_transmit_pin_sh : ir_sh[1]))
    else $error("infrared transmit wrong");
  ir_receive_a: assert property ($past(rstn && ce) |->
    uart2_rx_ff == $past(!iron_sh ? second_uart_receive_pin :
    ir_sh[2] && ir_tx_busy ? 1'b0 : infrared_receive_pin_sh))
    else $error("infrared receive wrong");
endmodule // ldmc_monitor
bind ldmc_config_bank ldmc_monitor i_ldmc_monitor (.core_clk, .rstn, .ce,
  .addr, .wr_data, .wr_stb, .ch2_data_access,
  .first_channel_buffer_enable_ff, .second_channel_buffer_enable_ff,
  .cs_low_req_n, .cs_high_req_n, .drive_chip_select_low_i,
  .drive_chip_select_low_o_ff, .drive_chip_select_low_oe_ff,
  .drive_chip_select_high_i, .drive_chip_select_high_o_ff,
  .drive_chip_select_high_oe_ff, .second_channel_irq_input_i,
  .second_channel_irq_input_oe_ff, .general_select_pin_i, .ch2_irq_ff,
  .upper_addr_ff, .upper_addr_valid_ff, .pp_nack_i, .pp_irq_o_ff,
  .pp_irq_oe_ff, .pp_fifo_thr_ff, .uart2_tx, .ir_tx_busy,
  .second_uart_receive_pin, .infrared_receive_pin, .uart2_rx_ff,
  .second_uart_transmit_pin_ff, .infrared_transmit_pin_ff);
`default_nettype wire

// *** verification/ldmc_host.sv ***
// Host model driving the register port
`default_nettype none
module ldmc_host (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [10:0] addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rd_data_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr, wr_data, wr_stb, rd_stb} = 21'h0;
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    // Released bus shows no stale value
    addr <= ~a;
    wr_data <= ~d;
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    @(posedge core_clk);
    d = rd_data_ff;
  endtask
endmodule // ldmc_host
`default_nettype wire

// *** verification/ldmc_config_bank_tb.sv ***
// Self-checking bench of the mode config bank
`default_nettype none
module ldmc_config_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rstn, ce, pp_irq_event;
  logic [12:0] rin;
  logic [31:0] rnd, r2;
  logic [7:0] rv;
  integer seed = 69629;
  int err_total = 0;
  int cmp_count = 0;
  wire [10:0] addr;
  wire [7:0] wr_data, rd_data_ff;
  wire wr_stb, rd_stb, cs_lo_o, cs_lo_oe, cs_hi_o, cs_hi_oe, vld, pio;
  wire [2:0] ppd;
  wire [3:0] thr, sp;
  wire [1:0] ird;
  wire cs_lo = cs_lo_oe ? cs_lo_o : rin[4];
  wire cs_hi = cs_hi_oe ? cs_hi_o : rin[5];
  logic [10:0] regs [8] = '{11'h024, 11'h230, 11'h2F0, 11'h3F0, 11'h4F0,
    11'h5F0, 11'h5F1, 11'h6F0};
  ldmc_host i_ldmc_host (.core_clk, .addr, .wr_data, .wr_stb, .rd_stb,
    .rd_data_ff);
  ldmc_config_bank i_ldmc_config_bank (
    .core_clk, .rstn, .ce, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data_ff,
    .ch1_data_access(rin[0]), .ch2_data_access(rin[1]),
    .first_channel_buffer_enable_ff(), .second_channel_buffer_enable_ff(),
    .cs_low_req_n(rin[2]), .cs_high_req_n(rin[3]),
    .drive_chip_select_low_i(cs_lo), .drive_chip_select_low_o_ff(cs_lo_o),
    .drive_chip_select_low_oe_ff(cs_lo_oe),
    .drive_chip_select_high_i(cs_hi), .drive_chip_select_high_o_ff(cs_hi_o),
    .drive_chip_select_high_oe_ff(cs_hi_oe),
    .second_channel_irq_input_i(rin[6]), .second_channel_irq_input_oe_ff(),
    .general_select_pin_i(rin[7]), .ch2_irq_ff(), .upper_addr_ff(),
    .upper_addr_valid_ff(vld), .pp_nack_i(rin[8]), .pp_irq_event,
    .pp_irq_o_ff(), .pp_irq_oe_ff(pio), .pp_epp19_ff(ppd[2]),
    .pp_epp17_ff(ppd[1]), .pp_ecp_ff(ppd[0]), .pp_fifo_thr_ff(thr),
    .sp1_midi_ff(sp[0]), .sp1_high_speed_ff(sp[1]), .sp2_midi_ff(sp[2]),
    .sp2_high_speed_ff(sp[3]), .uart2_tx(rin[9]), .ir_tx_busy(rin[10]),
    .uart2_rx_ff(), .second_uart_receive_pin(rin[11]),
    .second_uart_transmit_pin_ff(), .infrared_receive_pin(rin[12]),
    .infrared_transmit_pin_ff(), .ir_irda_ff(ird[1]), .ir_ask_ff(ird[0]));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    rnd = $random(seed);
    rin <= rnd[12:0];
  end
  function automatic logic [7:0] msk(input logic [10:0] a);
    if (a[7:0] == 8'h24) return 8'h40;
    case (a)
      11'h230, 11'h2F0: return 8'h01;
      11'h3F0: return 8'hFF;
      11'h4F0, 11'h5F0: return 8'h03;
      11'h5F1: return 8'h7F;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      i_ldmc_host.rd(regs[i], rv);
      chk("reset value", regs[i] == 11'h3F0 ? 8'h38 : 8'h00, rv);
    end
    $display("reset values done");
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    {rstn, ce, pp_irq_event, rin} = 16'h4000;
    do_reset();
    t_reset();
    repeat (40) begin
      r2 = $random(seed);
      i_ldmc_host.wr(regs[r2[2:0]], r2[15:8]);
      i_ldmc_host.rd(regs[r2[2:0]], rv);
      chk("readback", r2[15:8] & msk(regs[r2[2:0]]), rv);
    end
    $display("readback done");
    for (int m = 0; m < 16; m++) begin
      i_ldmc_host.wr(11'h3F0, {m[3], 4'h5, m[2:0]});
      settle();
      pp_irq_event <= 1'b1;
      settle();
      chk("pp irq driven", 8'h01, {7'h0, pio});
      pp_irq_event <= 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      chk("pp irq release", {7'h0, !m[3] || m[1:0] == 0},
        {7'h0, pio});
      chk("pp decodes", {5'h0, m[2:0] == 1, m[2:0] == 5, m[2:0] == 2},
        {5'h0, ppd});
      chk("fifo threshold", 8'h05, {4'h0, thr});
    end
    $display("parallel modes done");
    for (int c = 0; c < 16; c++) begin
      i_ldmc_host.wr(11'h5F1, {1'b1, c[3], c[2:0], c[1], c[3], c[0]});
      settle();
      chk("ir decodes", {6'h0, c[2:0] == 1, c[2:0] == 2}, {6'h0, ird});
    end
    $display("infrared done");
    for (int s = 0; s < 16; s++) begin
      i_ldmc_host.wr(11'h4F0, {6'h3F, s[1:0]});
      i_ldmc_host.wr(11'h5F0, {6'h00, s[3:2]});
      settle();
      chk("serial options", {4'h0, s[3:0]}, {4'h0, sp});
    end
    $display("serial done");
    for (int k = 0; k < 4; k++) begin
      i_ldmc_host.wr(11'h230, {7'h0, k[0]});
      i_ldmc_host.wr(11'h124, {1'b0, k[1], 6'h0});
      settle();
      chk("full decode", {7'h0, !k[0] && k[1]}, {7'h0, vld});
    end
    $display("channel pins done");
    // Strobe while frozen must leave the serial one register alone
    @(posedge core_clk);
    ce <= 1'b0;
    i_ldmc_host.wr(11'h4F0, 8'h00);
    ce <= 1'b1;
    i_ldmc_host.rd(11'h4F0, rv);
    chk("frozen register", 8'h03, rv);
    $display("clock enable done");
    i_ldmc_host.wr(11'h3F0, 8'h00);
    do_reset();
    t_reset();
    give_verdict();
  end
  // Whole run is near 700 cycles
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
endmodule // ldmc_config_bank_tb
`default_nettype wire
